/* File: design/plc_pkg.sv */
// Package for the parallel line controller: register map, reset values, bus carriers
package plc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_PIN_CONTROL_ENABLE   = 8'h00;
    localparam logic [7:0] OFS_PIN_CONTROL_DISABLE  = 8'h04;
    localparam logic [7:0] OFS_PIN_OWNERSHIP_STATUS = 8'h08;
    localparam logic [7:0] OFS_OUTPUT_DRIVER_ENABLE = 8'h10;
    localparam logic [7:0] OFS_OUTPUT_DRIVER_DISABLE = 8'h14;
    localparam logic [7:0] OFS_OUTPUT_DRIVER_STATUS = 8'h18;
    localparam logic [7:0] OFS_GLITCH_FILTER_ENABLE = 8'h20;
    localparam logic [7:0] OFS_GLITCH_FILTER_DISABLE = 8'h24;
    localparam logic [7:0] OFS_GLITCH_FILTER_STATUS = 8'h28;
    localparam logic [7:0] OFS_OUTPUT_DATA_SET      = 8'h30;
    localparam logic [7:0] OFS_OUTPUT_DATA_CLEAR    = 8'h34;
    localparam logic [7:0] OFS_OUTPUT_DATA_STATUS   = 8'h38;
    localparam logic [7:0] OFS_PIN_LEVEL_STATUS     = 8'h3C;

    // Address decode geometry
    localparam int         ADDR_W      = 8;
    localparam int         DATA_W      = 32;
    localparam int         LINES       = 32;
    localparam int         STRB_W      = 4;

    // Reset values
    localparam logic [31:0] OWN_RESET_FIRST  = 32'h03FFFFFF;
    localparam logic [31:0] OWN_RESET_SECOND = 32'h00FFFFFF;
    localparam logic [31:0] ZERO_RESET       = 32'h00000000;

    // AXI4-Lite response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register selector decoded from an address
    typedef enum logic [3:0] {
        PLC_SEL_NONE, PLC_SEL_PCE, PLC_SEL_PCD, PLC_SEL_OWN, PLC_SEL_ODE,
        PLC_SEL_ODD, PLC_SEL_ODS, PLC_SEL_GFE, PLC_SEL_GFD, PLC_SEL_GFS,
        PLC_SEL_DSET, PLC_SEL_DCLR, PLC_SEL_DSTAT, PLC_SEL_LVL
    } plc_sel_t;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } plc_axi_req_t;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } plc_axi_rsp_t;

endpackage : plc_pkg

/* File: design/plc_core.sv */
// Parallel line controller core: per-line ownership, driver, filter and data latch
`timescale 1ns/100ps
`default_nettype none
// Overview
// Thirty-two lines, each owned either by this controller or by its peripheral.
// Four pieces of per-line state: ownership, driver enable, filter select, data latch.
// Each piece has a set register and a clear register, written as bit masks.
// A written one acts on its line; a written zero leaves the line alone.
// Software never has to read, modify and write, so two masters cannot race.
// Status registers read the state back as it is stored.
//
// Ownership
// Ownership resets to a value picked by the instance parameter.
// Lines above the reset mask start with their peripheral.
// A peripheral-owned line keeps the peripheral's own level and enable at the pad.
// A controller-owned line drives the latch, but only where its driver is on.
// The peripheral input of a controller-owned line is forced low.
// That stops a peripheral from acting on a level it no longer owns.
//
// Driver and data latch
// Driver and latch bits are always stored, whoever owns the line.
// They reach the pad only while the controller owns the line.
// Handing a line back therefore restores the last programmed drive at once.
// Software should program latch and driver before taking a line back.
// Otherwise the pad may briefly show a stale level.
//
// Input path
// Every pad input passes two flops before any logic looks at it.
// A third flop keeps the previous synchronised sample for the filter.
// Unfiltered lines take the second flop straight into the level.
// Filtered lines move only when two samples in a row agree.
// A pulse of one clock thus never reaches the level or the peripheral.
// The filter costs one more clock of latency on filtered lines.
// The filter acts whatever the ownership of the line.
// The level register feeds both the peripheral input and the status read.
// With the clock stopped all flops hold, so the level holds too.
//
// Register bus
// Write address and write data are taken in either order.
// Each half is held until both are in, then the write happens.
// The response goes out two clocks after the later half is taken.
// No new write half is taken until that response is accepted.
// A read is answered one clock after its address is taken.
// Read data stand with the response until the master accepts it.
// Only one read and one write are ever open at a time.
// Reads and writes do not wait for each other.
//
// Responses
// Known set and clear registers answer OKAY.
// Status registers ignore writes and still answer OKAY.
// Set and clear registers read back as zero with OKAY.
// Reserved holes, misaligned and unmapped addresses answer SLVERR.
// An SLVERR read returns zero data.
// An SLVERR write changes nothing.
//
// Byte strobes
// Set and clear masks are cut by the byte strobes.
// A lane whose strobe is low acts as if written with zeros.
// For set and clear registers that simply means no effect.
//
// Timing seen from outside
// Register effect on the pads: one clock after the register updates.
// Peripheral level and enable to pads: one clock.
// Pad to level status: three clocks unfiltered, four filtered.
// Level to peripheral input: one more clock.
//
// Reset
// Reset is synchronous and clears every flop of the state.
// Ownership then takes its instance value.
// Driver, filter and latch come out of reset at zero.
// Pads neither drive nor show a level while reset is held.
// The bus ready signals rise at the first clock after release.
//
// Limitations
// No interrupts or open-drain control here.
// The level status resets to zero; after reset it follows the pads.
// The filter window is fixed at one clock of the controller clock.
// A slower controller clock widens the pulses that get dropped.
// Pulses near one period wide may pass or drop, depending on phase.

module plc_core
    import plc_pkg::*;
#(
    parameter bit SECOND_INSTANCE = 1'b0         // Selects ownership reset value
) (
    input  wire logic               clk_sys,     // System clock, 250 MHz
    input  wire logic               rst,         // Synchronous reset, active high
    input  wire plc_axi_req_t       axi_req,     // AXI4-Lite requests from master
    output var  plc_axi_rsp_t       axi_rsp,     // AXI4-Lite answers to master
    input  wire logic [LINES-1:0]   pin_in,      // Pad input levels, asynchronous
    output var  logic [LINES-1:0]   pin_out,     // Pad output levels
    output var  logic [LINES-1:0]   pin_oe,      // Pad output enables, high drives
    input  wire logic [LINES-1:0]   periph_out,  // Peripheral output levels
    input  wire logic [LINES-1:0]   periph_oe,   // Peripheral output enables
    output var  logic [LINES-1:0]   periph_in    // Input seen by peripherals
);

    // Complete module state
    typedef struct packed {
        logic [LINES-1:0]  sync_a;     // First synchroniser stage
        logic [LINES-1:0]  sync_b;     // Second synchroniser stage
        logic [LINES-1:0]  sync_c;     // Previous synchronised sample
        logic [LINES-1:0]  level;      // Filtered or direct input level
        logic [LINES-1:0]  own;        // Controller ownership
        logic [LINES-1:0]  drv;        // Output driver enables
        logic [LINES-1:0]  filt;       // Glitch filter selection
        logic [LINES-1:0]  odata;      // Output data latch
        logic [LINES-1:0]  pad_out;
        logic [LINES-1:0]  pad_oe;
        logic [LINES-1:0]  per_in;
        logic              aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_held;
        logic [DATA_W-1:0] w_data;
        logic [STRB_W-1:0] w_strb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } plc_state_t;

    localparam logic [LINES-1:0] OWN_RESET =
        SECOND_INSTANCE ? OWN_RESET_SECOND : OWN_RESET_FIRST;

    plc_state_t state_reg;
    plc_state_t state_next;

    // Map a word address to its register; reserved holes decode to none
    function automatic plc_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
        plc_sel_t sel;
        sel = PLC_SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr)
                OFS_PIN_CONTROL_ENABLE:    sel = PLC_SEL_PCE;
                OFS_PIN_CONTROL_DISABLE:   sel = PLC_SEL_PCD;
                OFS_PIN_OWNERSHIP_STATUS:  sel = PLC_SEL_OWN;
                OFS_OUTPUT_DRIVER_ENABLE:  sel = PLC_SEL_ODE;
                OFS_OUTPUT_DRIVER_DISABLE: sel = PLC_SEL_ODD;
                OFS_OUTPUT_DRIVER_STATUS:  sel = PLC_SEL_ODS;
                OFS_GLITCH_FILTER_ENABLE:  sel = PLC_SEL_GFE;
                OFS_GLITCH_FILTER_DISABLE: sel = PLC_SEL_GFD;
                OFS_GLITCH_FILTER_STATUS:  sel = PLC_SEL_GFS;
                OFS_OUTPUT_DATA_SET:       sel = PLC_SEL_DSET;
                OFS_OUTPUT_DATA_CLEAR:     sel = PLC_SEL_DCLR;
                OFS_OUTPUT_DATA_STATUS:    sel = PLC_SEL_DSTAT;
                OFS_PIN_LEVEL_STATUS:      sel = PLC_SEL_LVL;
                default:                   sel = PLC_SEL_NONE;
            endcase
        end
        return sel;
    endfunction : decode_addr

    // Expand byte strobes so a set/clear only touches written lanes
    function automatic logic [DATA_W-1:0] lane_bits(input logic [DATA_W-1:0] data,
                                                    input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] mask;
        mask = '0;
        for (int i = 0; i < STRB_W; i++) begin
            mask[i*8 +: 8] = {8{strb[i]}};
        end
        return data & mask;
    endfunction : lane_bits

    // Next-state logic
    always_comb begin
        plc_sel_t          wsel;
        plc_sel_t          rsel;
        logic [DATA_W-1:0] wbits;
        logic              aw_take;
        logic              w_take;
        logic              ar_take;
        logic              do_write;
        logic [LINES-1:0]  stable;

        state_next = state_reg;
        wsel       = decode_addr(state_reg.aw_addr);
        rsel       = decode_addr(axi_req.araddr);
        wbits      = lane_bits(state_reg.w_data, state_reg.w_strb);
        aw_take    = axi_req.awvalid & state_reg.awready;
        w_take     = axi_req.wvalid & state_reg.wready;
        ar_take    = axi_req.arvalid & state_reg.arready;
        do_write   = state_reg.aw_held & state_reg.w_held & ~state_reg.bvalid;
        stable     = ~(state_reg.sync_b ^ state_reg.sync_c);

        // Two-stage synchroniser, then one more sample for the filter
        state_next.sync_a = pin_in;
        state_next.sync_b = state_reg.sync_a;
        state_next.sync_c = state_reg.sync_b;

        // Filtered lines only move once two samples agree, so a pulse of
        // one clock never reaches the level; unfiltered lines pass direct
        for (int i = 0; i < LINES; i++) begin
            if (state_reg.filt[i]) begin
                if (stable[i]) begin
                    state_next.level[i] = state_reg.sync_c[i];
                end
            end else begin
                state_next.level[i] = state_reg.sync_b[i];
            end
        end

        // Peripheral input forced low on controller-owned lines
        state_next.per_in = state_reg.level & ~state_reg.own;

        // Pad mux: controller latch and driver, or the peripheral's own
        state_next.pad_oe  = (state_reg.own & state_reg.drv)
                           | (~state_reg.own & periph_oe);
        state_next.pad_out = (state_reg.own & state_reg.odata)
                           | (~state_reg.own & periph_out);

        // Write address and data are captured independently
        if (aw_take) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = axi_req.awaddr;
        end
        if (w_take) begin
            state_next.w_held = 1'b1;
            state_next.w_data = axi_req.wdata;
            state_next.w_strb = axi_req.wstrb;
        end

        // Register write once both halves are in
        if (do_write) begin
            state_next.aw_held = 1'b0;
            state_next.w_held  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = RESP_OKAY;
            case (wsel)
                PLC_SEL_PCE:  state_next.own   = state_reg.own | wbits;
                PLC_SEL_PCD:  state_next.own   = state_reg.own & ~wbits;
                PLC_SEL_ODE:  state_next.drv   = state_reg.drv | wbits;
                PLC_SEL_ODD:  state_next.drv   = state_reg.drv & ~wbits;
                PLC_SEL_GFE:  state_next.filt  = state_reg.filt | wbits;
                PLC_SEL_GFD:  state_next.filt  = state_reg.filt & ~wbits;
                PLC_SEL_DSET: state_next.odata = state_reg.odata | wbits;
                PLC_SEL_DCLR: state_next.odata = state_reg.odata & ~wbits;
                // Status registers ignore writes without complaint
                PLC_SEL_OWN, PLC_SEL_ODS, PLC_SEL_GFS,
                PLC_SEL_DSTAT, PLC_SEL_LVL: state_next.bresp = RESP_OKAY;
                default:      state_next.bresp = RESP_SLVERR;
            endcase
        end
        if (state_reg.bvalid && axi_req.bready) begin
            state_next.bvalid = 1'b0;
        end

        // Accept a new address or data only when that half is free
        state_next.awready = ~state_next.aw_held & ~state_next.bvalid;
        state_next.wready  = ~state_next.w_held & ~state_next.bvalid;

        // Read: value sampled at the address handshake
        if (ar_take) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = RESP_OKAY;
            case (rsel)
                PLC_SEL_OWN:   state_next.rdata = state_reg.own;
                PLC_SEL_ODS:   state_next.rdata = state_reg.drv;
                PLC_SEL_GFS:   state_next.rdata = state_reg.filt;
                PLC_SEL_DSTAT: state_next.rdata = state_reg.odata;
                PLC_SEL_LVL:   state_next.rdata = state_reg.level;
                // Write-only registers read back as zero
                PLC_SEL_PCE, PLC_SEL_PCD, PLC_SEL_ODE, PLC_SEL_ODD,
                PLC_SEL_GFE, PLC_SEL_GFD, PLC_SEL_DSET,
                PLC_SEL_DCLR:  state_next.rdata = ZERO_RESET;
                default: begin
                    state_next.rdata = ZERO_RESET;
                    state_next.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (state_reg.rvalid && axi_req.rready) begin
            state_next.rvalid = 1'b0;
        end
        state_next.arready = ~state_next.rvalid & ~ar_take;
    end

    // State register; a stopped clock freezes filter and level as they are
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg         <= '0;
            state_reg.own     <= OWN_RESET;
            state_reg.drv     <= ZERO_RESET;
            state_reg.filt    <= ZERO_RESET;
            state_reg.odata   <= ZERO_RESET;
            state_reg.bresp   <= RESP_OKAY;
            state_reg.rresp   <= RESP_OKAY;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from state flops
    // No logic sits between flop and port, so pads see no glitches
    // and the bus answer is stable for the whole cycle
    always_comb begin
        axi_rsp.awready = state_reg.awready;
        axi_rsp.wready  = state_reg.wready;
        axi_rsp.bvalid  = state_reg.bvalid;
        axi_rsp.bresp   = state_reg.bresp;
        axi_rsp.arready = state_reg.arready;
        axi_rsp.rvalid  = state_reg.rvalid;
        axi_rsp.rdata   = state_reg.rdata;
        axi_rsp.rresp   = state_reg.rresp;
        pin_out         = state_reg.pad_out;
        pin_oe          = state_reg.pad_oe;
        periph_in       = state_reg.per_in;
    end

endmodule : plc_core
`default_nettype wire

/* File: verif/plc_pad_model.sv */
// Pad and board model facing the parallel line controller pins
`timescale 1ns/100ps
`default_nettype none
module plc_pad_model
    import plc_pkg::*;
(
    input  wire logic [LINES-1:0] pin_out,   // Chip pad level
    input  wire logic [LINES-1:0] pin_oe,    // Chip pad enable
    input  wire logic [LINES-1:0] ext_level, // Board pull level where undriven
    output var  logic [LINES-1:0] pin_in     // Resolved pad wire
);
    // Chip wins where it drives; board pull elsewhere, never a stale value
    assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : plc_pad_model
`default_nettype wire

/* File: verif/plc_core_properties.sv */
// Concurrent checks on the parallel line controller ports
`timescale 1ns/100ps
`default_nettype none
module plc_core_properties
    import plc_pkg::*;
(
    input wire logic             clk_sys,   // System clock
    input wire logic             rst,       // Synchronous reset
    input wire plc_axi_req_t     axi_req,   // Bus requests
    input wire plc_axi_rsp_t     axi_rsp,   // Bus answers
    input wire logic [LINES-1:0] pin_out,   // Pad levels
    input wire logic [LINES-1:0] pin_oe,    // Pad enables
    input wire logic [LINES-1:0] periph_in  // Peripheral inputs
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Bus answer timing and holding
    property p_rd_lat;
        axi_req.arvalid && axi_rsp.arready |-> ##[1:2] axi_rsp.rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_rd_hold;
        axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    property p_wr_lat;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
            |-> ##[1:2] axi_rsp.bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    property p_b_hold;
        axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_aw_busy;
        axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready;
    endproperty
    a_aw_busy: assert property (p_aw_busy) else $error("second write taken");
    property p_one_read;
        axi_rsp.rvalid |-> !axi_rsp.arready;
    endproperty
    a_one_read: assert property (p_one_read) else $error("second read open");
    property p_err_zero;
        axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR |-> axi_rsp.rdata == ZERO_RESET;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    // Reset checks run while reset is high, so no disable
    property p_rst_pads;
        disable iff (1'b0) rst |=> pin_oe == ZERO_RESET && pin_out == ZERO_RESET;
    endproperty
    a_rst_pads: assert property (p_rst_pads) else $error("pads driven in reset");
    property p_rst_periph;
        disable iff (1'b0) rst |=> periph_in == ZERO_RESET;
    endproperty
    a_rst_periph: assert property (p_rst_periph) else $error("periph input set");
    c_write: cover property (axi_rsp.bvalid && axi_req.bready);
    c_read: cover property (axi_rsp.rvalid && axi_req.rready);
    c_err: cover property (axi_rsp.bvalid && axi_rsp.bresp == RESP_SLVERR);
endmodule : plc_core_properties
bind plc_core plc_core_properties u_props (.clk_sys(clk_sys), .rst(rst), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .pin_out(pin_out), .pin_oe(pin_oe), .periph_in(periph_in));
`default_nettype wire

/* File: verif/pin_io_control_core_bench.sv */
// Self-checking bench for the parallel line controller core
`timescale 1ns/100ps
`default_nettype none
module pin_io_control_core_bench;
    import plc_pkg::*;
    logic             clk_sys;     // System clock
    logic             rst;         // Reset
    plc_axi_req_t     req;         // Bus requests
    plc_axi_rsp_t     rsp;         // Bus answers
    logic [LINES-1:0] pin_in;      // Resolved pads
    logic [LINES-1:0] pin_out;     // Pad levels
    logic [LINES-1:0] pin_oe;      // Pad enables
    logic [LINES-1:0] periph_out;  // Peripheral levels
    logic [LINES-1:0] periph_oe;   // Peripheral enables
    logic [LINES-1:0] periph_in;   // Peripheral inputs
    logic [LINES-1:0] ext_level;   // Board levels
    logic [1:0]       seen_low;    // Sticky lows on lines 10 and 9
    logic             seen_clr;    // Clears the sticky lows
    plc_axi_req_t     req_idle;    // Idle bus for the second instance
    logic [LINES-1:0] per_second;  // Peripheral inputs, second instance
    int               n_errors;
    int               checks_done;
    plc_core uut (.clk_sys(clk_sys), .rst(rst), .axi_req(req), .axi_rsp(rsp), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out), .periph_oe(periph_oe),
        .periph_in(periph_in));
    plc_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_in(pin_in));
    // Second instance only shows its ownership reset through the peripheral inputs
    plc_core #(.SECOND_INSTANCE(1'b1)) uut_second (.clk_sys(clk_sys), .rst(rst),
        .axi_req(req_idle), .axi_rsp(), .pin_in(ext_level), .pin_out(), .pin_oe(),
        .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(per_second));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // Catch single-cycle pulses that a sampled read would miss
    always @(posedge clk_sys) begin
        if (seen_clr) seen_low <= 2'h0;
        else seen_low <= seen_low | ~periph_in[10:9];
    end
    task automatic results();
        if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_up();
        n_errors++;
        results();
    endtask : give_up
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge clk_sys);
        req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hF, bready: 1'b1,
            default: '0};
        do begin
            @(posedge clk_sys);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                req.bready <= 1'b0;
                chk(32'(rsp.bresp), 32'(er));
                return;
            end
        end while (n < 100);
        give_up();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n = 0;
        @(posedge clk_sys);
        req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
        do begin
            @(posedge clk_sys);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                req.rready <= 1'b0;
                chk(rsp.rdata, e);
                chk(32'(rsp.rresp), 32'(er));
                return;
            end
        end while (n < 100);
        give_up();
    endtask : rd
    // Reset values of every status register except the level status
    task automatic t_reset();
        rd(OFS_PIN_OWNERSHIP_STATUS, OWN_RESET_FIRST, RESP_OKAY);
        rd(OFS_OUTPUT_DRIVER_STATUS, 32'h00000000, RESP_OKAY);
        rd(OFS_GLITCH_FILTER_STATUS, 32'h00000000, RESP_OKAY);
        rd(OFS_OUTPUT_DATA_STATUS, 32'h00000000, RESP_OKAY);
    endtask : t_reset
    // Hand lines 0..3 away, take line 0 back, zero writes change nothing
    task automatic t_own();
        wr(OFS_PIN_CONTROL_DISABLE, 32'h0000000F, RESP_OKAY);
        rd(OFS_PIN_OWNERSHIP_STATUS, 32'h03FFFFF0, RESP_OKAY);
        wr(OFS_PIN_CONTROL_ENABLE, 32'h00000001, RESP_OKAY);
        wr(OFS_PIN_CONTROL_DISABLE, 32'h00000000, RESP_OKAY);
        rd(OFS_PIN_OWNERSHIP_STATUS, 32'h03FFFFF1, RESP_OKAY);
        chk(per_second, ~OWN_RESET_SECOND);
    endtask : t_own
    // Driver and data latch on owned and peripheral lines, seen at the pads
    task automatic t_drive();
        wr(OFS_OUTPUT_DRIVER_ENABLE, 32'h000000FF, RESP_OKAY);
        wr(OFS_OUTPUT_DRIVER_DISABLE, 32'h0000000F, RESP_OKAY);
        rd(OFS_OUTPUT_DRIVER_STATUS, 32'h000000F0, RESP_OKAY);
        wr(OFS_OUTPUT_DATA_SET, 32'h00000050, RESP_OKAY);
        wr(OFS_OUTPUT_DATA_CLEAR, 32'h00000010, RESP_OKAY);
        wr(OFS_OUTPUT_DATA_SET, 32'h00000004, RESP_OKAY);
        rd(OFS_OUTPUT_DATA_STATUS, 32'h00000044, RESP_OKAY);
        repeat (8) @(posedge clk_sys);
        chk(pin_oe, 32'h000000FE);
        chk(pin_out & pin_oe, 32'h0000004A);
        chk(periph_in, 32'hFC00000A);
        rd(OFS_PIN_LEVEL_STATUS, 32'hFFFFFF4B, RESP_OKAY);
    endtask : t_drive
    // Filter on peripheral lines: line 9 drops a one-cycle low, line 10 passes it
    task automatic t_filter();
        wr(OFS_PIN_CONTROL_DISABLE, 32'h00000600, RESP_OKAY);
        wr(OFS_GLITCH_FILTER_ENABLE, 32'h00000600, RESP_OKAY);
        rd(OFS_GLITCH_FILTER_STATUS, 32'h00000600, RESP_OKAY);
        wr(OFS_GLITCH_FILTER_DISABLE, 32'h00000400, RESP_OKAY);
        rd(OFS_GLITCH_FILTER_STATUS, 32'h00000200, RESP_OKAY);
        repeat (8) @(posedge clk_sys);
        seen_clr <= 1'b1;
        @(posedge clk_sys);
        seen_clr <= 1'b0;
        ext_level[10:9] <= 2'h0;
        @(posedge clk_sys);
        ext_level[10:9] <= 2'h3;
        repeat (8) @(posedge clk_sys);
        chk(32'(seen_low), 32'h00000002);
    endtask : t_filter
    // Reserved, unmapped, write-only and read-only places
    task automatic t_refuse();
        wr(8'h0C, 32'hFFFFFFFF, RESP_SLVERR);
        rd(8'h0C, 32'h00000000, RESP_SLVERR);
        rd(8'h44, 32'h00000000, RESP_SLVERR);
        rd(OFS_PIN_CONTROL_DISABLE, 32'h00000000, RESP_OKAY);
        wr(OFS_PIN_OWNERSHIP_STATUS, 32'h00000000, RESP_OKAY);
        rd(OFS_PIN_OWNERSHIP_STATUS, 32'h03FFF9F1, RESP_OKAY);
    endtask : t_refuse
    initial begin
        n_errors = 0;
        checks_done = 0;
        rst = 1'b1;
        req = '0;
        periph_out = 32'h0000000A;
        periph_oe = 32'h0000000E;
        ext_level = 32'hFFFFFFFF;
        seen_clr = 1'b1;
        req_idle = '0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_own();
        t_drive();
        t_filter();
        t_refuse();
        results();
    end
endmodule : pin_io_control_core_bench
`default_nettype wire
